// >>> core/mcu_pin_function_mux.v
// Purpose: pin function multiplexer of a 16-bit microcontroller
// Assumes: single clock, pins sampled through two flip-flops
// Notes: pin outputs and enables are registered, one cycle late
// Function
// - bus mode: port 0 low address/data
// - bus mode: port 1 middle address/high data
// - bus mode: port 2 drives address 16-23
// - bus mode: address latch strobe on port 3
// - bus mode: read strobe on port 3
// - bus mode: separate low/high write strobes
// - bus mode: hold request in, hold acknowledge out
// - bus mode: ready input sampled
// - bus mode: bus clock out on port 3
// - ports 0,1,6 pull-ups only when input
// - port 4 open-drain selectable per pin
// - serial transmit only when data output enabled
// - serial clock out only when enabled
// - pulse outputs only when channel enabled
// - compare outputs only for enabled channels
// - port 9 chip selects only when enabled
// - port 8 analog inputs only when enabled
// - clock monitor only when output enabled
// - variant: interrupts 0,1 cannot wake stop
// - port A routes counter and interrupt inputs
`include "mcu_pin_mux_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module mcu_pin_function_mux #(
	parameter BOTH_EDGE_IRQ01 = 1'b0
) (
	// clock and reset
	input wire clock,
	input wire sys_rst,
	// mode straps
	input wire [`MODE_WIDTH-1:0] modeSelectPin,
	output wire extBusMode,
	// pins: input, output, output enable, pull-up enable
	input wire [7:0] port0PinIn,
	output wire [7:0] port0PinOut,
	output wire [7:0] port0PinOe,
	output wire [7:0] port0PullEn,
	input wire [7:0] port1PinIn,
	output wire [7:0] port1PinOut,
	output wire [7:0] port1PinOe,
	output wire [7:0] port1PullEn,
	input wire [7:0] port2PinIn,
	output wire [7:0] port2PinOut,
	output wire [7:0] port2PinOe,
	input wire [7:0] port3PinIn,
	output wire [7:0] port3PinOut,
	output wire [7:0] port3PinOe,
	input wire [7:0] port4PinIn,
	output wire [7:0] port4PinOut,
	output wire [7:0] port4PinOe,
	input wire [7:0] port6PinIn,
	output wire [7:0] port6PinOut,
	output wire [7:0] port6PinOe,
	output wire [7:0] port6PullEn,
	input wire [7:0] port8PinIn,
	output wire [7:0] port8PinOut,
	output wire [7:0] port8PinOe,
	input wire [7:0] port9PinIn,
	output wire [7:0] port9PinOut,
	output wire [7:0] port9PinOe,
	input wire [7:0] portAPinIn,
	output wire [7:0] portAPinOut,
	output wire [7:0] portAPinOe,
	input wire [7:0] portBPinIn,
	output wire [7:0] portBPinOut,
	output wire [7:0] portBPinOe,
	// general-purpose port data and direction
	input wire [79:0] portData,
	input wire [79:0] portDirection,
	output wire [79:0] portRead,
	// pull-up and open-drain selections
	input wire [7:0] port0PullupSel,
	input wire [7:0] port1PullupSel,
	input wire [7:0] port6PullupSel,
	input wire [7:0] port4OpendrainSel,
	// external bus controller side
	input wire [23:0] busAddr,
	input wire [15:0] busWriteData,
	input wire busAddrPhase,
	input wire busDataDrive,
	output wire [15:0] busReadData,
	input wire addrLatchEn,
	input wire readStrobe,
	input wire writeStrobeLow,
	input wire writeStrobeHigh,
	input wire busClock,
	input wire holdAckOut,
	output wire holdRequestIn,
	output wire busReady,
	// serial channels
	input wire [1:0] uartTxData,
	input wire [1:0] uartTxEn,
	input wire [1:0] uartClkOut,
	input wire [1:0] uartClkOutEn,
	output wire [1:0] uartRxData,
	output wire [1:0] uartClkIn,
	// pulse, compare, chip select, clock monitor
	input wire [1:0] pulseGenOut,
	input wire [1:0] pulseGenEn,
	input wire [3:0] compareEventOut,
	input wire [3:0] compareEventEn,
	input wire [7:0] chipSelectOut,
	input wire chipSelectEn,
	input wire clockMonitorOut,
	input wire clockMonitorEn,
	// analog inputs
	input wire [7:0] analogInEn,
	output wire [7:0] analogInSelect,
	// two-wire bus
	input wire twoWireEn,
	input wire twoWireSdaOut,
	input wire twoWireSclOut,
	output wire twoWireSdaIn,
	output wire twoWireSclIn,
	// counter, interrupt and trigger inputs
	output wire [1:0] countAInput,
	output wire [1:0] countBInput,
	output wire [1:0] countZInput,
	output wire [7:0] extInterruptIn,
	output wire [7:0] extInterruptStopWake,
	output wire converterTriggerIn
);

	// ************************************************
	// helpers
	// ************************************************

	// per-bit choice between alternate and port value
	function [7:0] sel8;
		input [7:0] en;
		input [7:0] alt;
		input [7:0] gpio;
		begin
			sel8 = (en & alt) | (~en & gpio);
		end
	endfunction

	// ************************************************
	// input synchronisers
	// ************************************************
	reg [`PIN_TOTAL-1:0] pinMeta_reg;
	reg [`PIN_TOTAL-1:0] pinSync_reg;
	reg [`MODE_WIDTH-1:0] modeMeta_reg;
	reg [`MODE_WIDTH-1:0] modeSync_reg;
	wire [`PIN_TOTAL-1:0] pinRaw;

	assign pinRaw = {portBPinIn, portAPinIn, port9PinIn, port8PinIn, port6PinIn,
		port4PinIn, port3PinIn, port2PinIn, port1PinIn, port0PinIn};

	// two flip-flops on every pin and strap
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pinMeta_reg <= {`PIN_TOTAL{1'b0}};
			pinSync_reg <= {`PIN_TOTAL{1'b0}};
			modeMeta_reg <= {`MODE_WIDTH{1'b0}};
			modeSync_reg <= {`MODE_WIDTH{1'b0}};
		end
		else
		begin
			pinMeta_reg <= pinRaw;
			pinSync_reg <= pinMeta_reg;
			modeMeta_reg <= modeSelectPin;
			modeSync_reg <= modeMeta_reg;
		end
	end

	// ************************************************
	// mode strap capture
	// ************************************************
	reg [1:0] modeCnt_reg;
	reg extBus_reg;

	// strap caught once the synchroniser has filled
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			modeCnt_reg <= 2'h0;
			extBus_reg <= 1'b0;
		end
		else if (modeCnt_reg < `MODE_CAPTURE_CNT)
		begin
			modeCnt_reg <= modeCnt_reg + 2'h1;
		end
		else if (modeCnt_reg == `MODE_CAPTURE_CNT)
		begin
			modeCnt_reg <= 2'h3;
			extBus_reg <= (modeSync_reg != `MODE_SINGLE_CHIP);
		end
		else
		begin
			// captured: mode held until the next reset
			modeCnt_reg <= 2'h3;
		end
	end

	assign extBusMode = extBus_reg;

	// ************************************************
	// external bus ports 0 to 3
	// ************************************************
	wire busOwn;
	wire [7:0] ext8;
	wire [7:0] busOe8;
	wire [7:0] p0Out;
	wire [7:0] p0Oe;
	wire [7:0] p1Out;
	wire [7:0] p1Oe;
	wire [7:0] p2Out;
	wire [7:0] p2Oe;
	wire [7:0] p3Alt;
	wire [7:0] p3AltOe;
	wire [7:0] p3Out;
	wire [7:0] p3Oe;

	// bus pins released while hold is acknowledged
	assign busOwn = extBus_reg & ~holdAckOut;
	assign ext8 = {8{extBus_reg}};
	assign busOe8 = {8{busOwn & (busAddrPhase | busDataDrive)}};

	// multiplexed address and data on ports 0 and 1
	assign p0Out = sel8(ext8, busAddrPhase ? busAddr[7:0] : busWriteData[7:0], portData[7:0]);
	assign p0Oe = sel8(ext8, busOe8, portDirection[7:0]);
	assign p1Out = sel8(ext8, busAddrPhase ? busAddr[15:8] : busWriteData[15:8], portData[15:8]);
	assign p1Oe = sel8(ext8, busOe8, portDirection[15:8]);

	// upper address on port 2
	assign p2Out = sel8(ext8, busAddr[23:16], portData[23:16]);
	assign p2Oe = sel8(ext8, {8{busOwn}}, portDirection[23:16]);

	// strobes, hold handshake, ready and clock on port 3
	assign p3Alt = {busClock, 1'b0, holdAckOut, 1'b0, writeStrobeHigh, writeStrobeLow,
		readStrobe, addrLatchEn};
	assign p3AltOe = {1'b1, 1'b0, 1'b1, 1'b0, {4{busOwn}}};
	assign p3Out = sel8(ext8, p3Alt, portData[31:24]);
	assign p3Oe = sel8(ext8, p3AltOe, portDirection[31:24]);

	// hold and ready inputs quiet in single-chip mode, read data always passed
	assign holdRequestIn = extBus_reg & pinSync_reg[`P3_LSB+`P3_HOLD_REQ];
	assign busReady = ~extBus_reg | pinSync_reg[`P3_LSB+`P3_READY];
	assign busReadData = pinSync_reg[`P1_LSB+7:`P0_LSB];

	// ************************************************
	// port 4 serial, pulse and open drain
	// ************************************************
	wire [7:0] p4En;
	wire [7:0] p4Alt;
	wire [7:0] p4RawOut;
	wire [7:0] p4RawOe;
	wire [7:0] p4Out;
	wire [7:0] p4Oe;

	// alternate drivers win only while enabled
	assign p4En = {pulseGenEn, uartClkOutEn[1], uartTxEn[1], 1'b0,
		uartClkOutEn[0], uartTxEn[0], 1'b0};
	assign p4Alt = {pulseGenOut, uartClkOut[1], uartTxData[1], 1'b0,
		uartClkOut[0], uartTxData[0], 1'b0};
	assign p4RawOut = sel8(p4En, p4Alt, portData[39:32]);
	assign p4RawOe = p4En | portDirection[39:32];

	// open-drain pins only pull low
	assign p4Out = p4RawOut & ~port4OpendrainSel;
	assign p4Oe = sel8(port4OpendrainSel, p4RawOe & ~p4RawOut, p4RawOe);

	// receivers and clock inputs read the pins continuously
	assign uartRxData = {pinSync_reg[`P4_LSB+`P4_RX1], pinSync_reg[`P4_LSB+`P4_RX0]};
	assign uartClkIn = {pinSync_reg[`P4_LSB+`P4_CLK1], pinSync_reg[`P4_LSB+`P4_CLK0]};

	// ************************************************
	// port 6 clock monitor and compare outputs
	// ************************************************
	wire [7:0] p6En;
	wire [7:0] p6Out;
	wire [7:0] p6Oe;

	assign p6En = {compareEventEn, clockMonitorEn, 3'h0};
	assign p6Out = sel8(p6En, {compareEventOut, clockMonitorOut, 3'h0}, portData[47:40]);
	assign p6Oe = p6En | portDirection[47:40];

	// ************************************************
	// ports 8, 9, A and B
	// ************************************************
	wire [7:0] p8Oe;
	wire [7:0] p9En;
	wire [7:0] p9Out;
	wire [7:0] p9Oe;
	wire [7:0] paEn;
	wire [7:0] paOut;
	wire [7:0] paOe;

	// analog pins lose their digital driver
	assign p8Oe = portDirection[`P8_LSB+7:`P8_LSB] & ~analogInEn;

	// chip selects take the whole port
	assign p9En = {8{chipSelectEn}};
	assign p9Out = sel8(p9En, chipSelectOut, portData[`P9_LSB+7:`P9_LSB]);
	assign p9Oe = p9En | portDirection[`P9_LSB+7:`P9_LSB];

	// two-wire pins are open drain while the interface runs
	assign paEn = {{2{twoWireEn}}, 6'h00};
	assign paOut = sel8(paEn, 8'h00, portData[`PA_LSB+7:`PA_LSB]);
	assign paOe = portDirection[`PA_LSB+7:`PA_LSB] | (paEn & {~twoWireSclOut, ~twoWireSdaOut, 6'h00});

	assign twoWireSdaIn = pinSync_reg[`PA_LSB+`PA_SDA];
	assign twoWireSclIn = pinSync_reg[`PA_LSB+`PA_SCL];

	// counter and interrupt inputs shared on port A
	assign countAInput = {pinSync_reg[`PA_LSB+3], pinSync_reg[`PA_LSB+0]};
	assign countBInput = {pinSync_reg[`PA_LSB+4], pinSync_reg[`PA_LSB+1]};
	assign countZInput = {pinSync_reg[`PA_LSB+5], pinSync_reg[`PA_LSB+2]};
	assign extInterruptIn = {pinSync_reg[`PA_LSB+3], pinSync_reg[`PA_LSB+0],
		pinSync_reg[`PB_LSB+5:`PB_LSB]};
	assign converterTriggerIn = pinSync_reg[`PB_LSB+`PB_TRIGGER];

	// both-edge variant cannot wake from stop on lines 0 and 1
	assign extInterruptStopWake = {6'h3F, {2{~BOTH_EDGE_IRQ01}}};

	// ************************************************
	// output registers
	// ************************************************
	wire [`PIN_TOTAL-1:0] pinOut_next;
	wire [`PIN_TOTAL-1:0] pinOe_next;
	wire [23:0] pull_next;
	reg [`PIN_TOTAL-1:0] pinOut_reg;
	reg [`PIN_TOTAL-1:0] pinOe_reg;
	reg [23:0] pull_reg;
	reg [7:0] analogSel_reg;

	// port B has no alternate output
	assign pinOut_next = {portData[`PB_LSB+7:`PB_LSB], paOut, p9Out, portData[`P8_LSB+7:`P8_LSB],
		p6Out, p4Out, p3Out, p2Out, p1Out, p0Out};
	assign pinOe_next = {portDirection[`PB_LSB+7:`PB_LSB], paOe, p9Oe, p8Oe,
		p6Oe, p4Oe, p3Oe, p2Oe, p1Oe, p0Oe};

	// pull-ups only on pins not driving
	assign pull_next = {port6PullupSel & ~p6Oe, port1PullupSel & ~p1Oe,
		port0PullupSel & ~p0Oe};

	// all pins released during reset
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pinOut_reg <= {`PIN_TOTAL{1'b0}};
			pinOe_reg <= {`PIN_TOTAL{1'b0}};
			pull_reg <= 24'h000000;
			analogSel_reg <= 8'h00;
		end
		else
		begin
			pinOut_reg <= pinOut_next;
			pinOe_reg <= pinOe_next;
			pull_reg <= pull_next;
			analogSel_reg <= analogInEn;
		end
	end

	// ************************************************
	// pin and read-back outputs
	// ************************************************
	assign port0PinOut = pinOut_reg[`P0_LSB+7:`P0_LSB];
	assign port0PinOe = pinOe_reg[`P0_LSB+7:`P0_LSB];
	assign port1PinOut = pinOut_reg[`P1_LSB+7:`P1_LSB];
	assign port1PinOe = pinOe_reg[`P1_LSB+7:`P1_LSB];
	assign port2PinOut = pinOut_reg[`P2_LSB+7:`P2_LSB];
	assign port2PinOe = pinOe_reg[`P2_LSB+7:`P2_LSB];
	assign port3PinOut = pinOut_reg[`P3_LSB+7:`P3_LSB];
	assign port3PinOe = pinOe_reg[`P3_LSB+7:`P3_LSB];
	assign port4PinOut = pinOut_reg[`P4_LSB+7:`P4_LSB];
	assign port4PinOe = pinOe_reg[`P4_LSB+7:`P4_LSB];
	assign port6PinOut = pinOut_reg[`P6_LSB+7:`P6_LSB];
	assign port6PinOe = pinOe_reg[`P6_LSB+7:`P6_LSB];
	assign port8PinOut = pinOut_reg[`P8_LSB+7:`P8_LSB];
	assign port8PinOe = pinOe_reg[`P8_LSB+7:`P8_LSB];
	assign port9PinOut = pinOut_reg[`P9_LSB+7:`P9_LSB];
	assign port9PinOe = pinOe_reg[`P9_LSB+7:`P9_LSB];
	assign portAPinOut = pinOut_reg[`PA_LSB+7:`PA_LSB];
	assign portAPinOe = pinOe_reg[`PA_LSB+7:`PA_LSB];
	assign portBPinOut = pinOut_reg[`PB_LSB+7:`PB_LSB];
	assign portBPinOe = pinOe_reg[`PB_LSB+7:`PB_LSB];
	assign port0PullEn = pull_reg[7:0];
	assign port1PullEn = pull_reg[15:8];
	assign port6PullEn = pull_reg[23:16];
	assign analogInSelect = analogSel_reg;

	// analog pins read zero, their digital input is shut
	assign portRead = {pinSync_reg[`PIN_TOTAL-1:`P9_LSB], pinSync_reg[`P8_LSB+7:`P8_LSB] & ~analogSel_reg,
		pinSync_reg[`P8_LSB-1:0]};

endmodule // mcu_pin_function_mux

`default_nettype wire

// >>> core/mcu_pin_mux_consts.vh
// Purpose: constants for the pin function multiplexer
// Assumes: included by its bare name from core/ sources
// Notes: definitions only, no logic
`ifndef MCU_PIN_MUX_CONSTS_VH
`define MCU_PIN_MUX_CONSTS_VH

// ************************************************
// mode strap decode
// ************************************************
`define MODE_WIDTH 3
`define MODE_SINGLE_CHIP 3'h3
`define MODE_CAPTURE_CNT 2'h2

// ************************************************
// packed pin vector layout, eight pins per port
// ************************************************
`define PORT_WIDTH 8
`define PIN_TOTAL 80
`define P0_LSB 0
`define P1_LSB 8
`define P2_LSB 16
`define P3_LSB 24
`define P4_LSB 32
`define P6_LSB 40
`define P8_LSB 48
`define P9_LSB 56
`define PA_LSB 64
`define PB_LSB 72

// ************************************************
// port 3 bus control pin positions
// ************************************************
`define P3_ADDR_LATCH 0
`define P3_READ 1
`define P3_WRITE_LOW 2
`define P3_WRITE_HIGH 3
`define P3_HOLD_REQ 4
`define P3_HOLD_ACK 5
`define P3_READY 6
`define P3_BUS_CLOCK 7

// ************************************************
// port 4 serial pin positions
// ************************************************
`define P4_RX0 0
`define P4_TX0 1
`define P4_CLK0 2
`define P4_RX1 3
`define P4_TX1 4
`define P4_CLK1 5

// ************************************************
// port A and port B shared input positions
// ************************************************
`define PA_SDA 6
`define PA_SCL 7
`define PB_TRIGGER 6

`endif

// >>> dv/mcu_pin_function_mux_assertions.sv
// Purpose: concurrent checks on the pin function multiplexer ports
// Assumes: pin outputs are registered one cycle after their cause
// Notes: attached to every instance by the bind below the module
`timescale 1ns/1ps
`default_nettype none
module mcu_pin_mux_checker #(
	parameter BOTH_EDGE_IRQ01 = 1'b0
) (
	// clock, reset and mode
	input wire logic clock, sys_rst, extBusMode, holdAckOut, busAddrPhase, holdRequestIn, busReady,
	// bus and pin signals
	input wire logic [23:0] busAddr,
	input wire logic [7:0] port2PinOut, port2PinOe, port0PinOe, port3PinOut, port3PinOe, port0PullupSel, port0PullEn,
	input wire logic chipSelectEn,
	input wire logic [7:0] chipSelectOut, port9PinOut, port9PinOe, analogInEn, analogInSelect,
	input wire logic [1:0] uartTxEn, uartTxData,
	input wire logic [7:0] port4OpendrainSel, port4PinOut, port4PinOe, port6PinOut, port6PinOe,
	input wire logic [3:0] compareEventEn, compareEventOut,
	input wire logic [7:0] extInterruptStopWake
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// ************************************************
	// port relations
	// ************************************************
	upper_addr_a: assert property (extBusMode && busAddrPhase && !holdAckOut |=> port2PinOut == $past(busAddr[23:16])
		&& port2PinOe == 8'hFF) else $error("upper address not on port 2");
	hold_release_a: assert property (extBusMode && holdAckOut |=> port0PinOe == 8'h00 && port2PinOe == 8'h00
		&& port3PinOe[3:0] == 4'h0) else $error("bus pins driven in hold");
	hold_ack_a: assert property (extBusMode |=> port3PinOut[5] == $past(holdAckOut) && port3PinOe[5])
		else $error("hold acknowledge pin wrong");
	hold_gate_a: assert property (!extBusMode |-> !holdRequestIn) else $error("hold request outside bus mode");
	ready_idle_a: assert property (!extBusMode [*2] |-> busReady) else $error("ready low in single chip");
	pull_gate_a: assert property (1'b1 |=> port0PullEn == ($past(port0PullupSel) & ~port0PinOe))
		else $error("pull-up active on output");
	chip_select_a: assert property (chipSelectEn |=> port9PinOut == $past(chipSelectOut) && port9PinOe == 8'hFF)
		else $error("chip selects not on port 9");
	analog_sel_a: assert property (1'b1 |=> analogInSelect == $past(analogInEn))
		else $error("analog select lags");
	serial_tx_a: assert property (uartTxEn[0] && !port4OpendrainSel[1] |=> port4PinOut[1] == $past(uartTxData[0])
		&& port4PinOe[1]) else $error("transmit pin wrong");
	compare_out_a: assert property (compareEventEn[0] |=> port6PinOut[4] == $past(compareEventOut[0]) && port6PinOe[4])
		else $error("compare event pin wrong");
	stop_wake_a: assert property (extInterruptStopWake == {6'h3F, {2{~BOTH_EDGE_IRQ01}}})
		else $error("stop wake mask wrong");
endmodule // mcu_pin_mux_checker
bind mcu_pin_function_mux mcu_pin_mux_checker #(.BOTH_EDGE_IRQ01(BOTH_EDGE_IRQ01)) checker_inst (.*);
`default_nettype wire

// >>> dv/ext_bus_memory.sv
// Purpose: external memory and bus master on the multiplexed bus
// Assumes: strobes active high, pins resolved here
// Notes: released lines show the inverse of their last level
`timescale 1ns/1ps
`default_nettype none
module ext_bus_memory (
	// device pins
	input wire logic clock,
	input wire logic [7:0] p0Out, p0Oe, p1Out, p1Oe, p2Out, p3Out,
	// bench commands
	input wire logic holdWanted, slowReady,
	// levels seen at the pins
	output logic [7:0] p0In, p1In,
	output logic holdReq, readyLine
);
	logic [23:0] addrReg;
	logic [15:0] lastLvl = 16'h0000;
	logic [15:0] extDrive;
	// capture address on the latch strobe, remember wire levels
	always @(posedge clock)
	begin
		if (p3Out[0])
			addrReg <= {p2Out, p1Out, p0Out};
		lastLvl <= {p1In, p0In};
	end
	// read data while the read strobe is high, else a floating pattern
	assign extDrive = p3Out[1] ? (addrReg[15:0] ^ 16'h5A5A) : ~lastLvl;
	assign p0In = (p0Oe & p0Out) | (~p0Oe & extDrive[7:0]);
	assign p1In = (p1Oe & p1Out) | (~p1Oe & extDrive[15:8]);
	assign holdReq = holdWanted;
	assign readyLine = ~slowReady;
endmodule // ext_bus_memory
`default_nettype wire

// >>> dv/mcu_pin_function_mux_bench.sv
// Purpose: self-checking bench for the pin function multiplexer
// Assumes: inputs driven at the falling edge
// Notes: single-chip phase first, then a reset into bus mode
`timescale 1ns/1ps
`default_nettype none
module mcu_pin_function_mux_bench;
	logic clock, sys_rst, busAddrPhase, busDataDrive, addrLatchEn, readStrobe, writeStrobeLow, writeStrobeHigh;
	logic busClock, holdAckOut, chipSelectEn, clockMonitorOut, clockMonitorEn, twoWireEn, twoWireSdaOut;
	logic twoWireSclOut, extBusMode, holdRequestIn, busReady, twoWireSdaIn, twoWireSclIn, converterTriggerIn;
	logic holdWanted, slowReady, holdReq, readyLine;
	logic [2:0] modeSelectPin;
	logic [1:0] uartTxData, uartTxEn, uartClkOut, uartClkOutEn, pulseGenOut, pulseGenEn, uartRxData, uartClkIn;
	logic [1:0] countAInput, countBInput, countZInput;
	logic [3:0] compareEventOut, compareEventEn;
	logic [15:0] busWriteData, busReadData;
	logic [23:0] busAddr;
	logic [79:0] portData, portDirection, portRead;
	logic [7:0] port0PinIn, port1PinIn, port2PinIn, port3PinIn, port4PinIn, port6PinIn, port8PinIn, port9PinIn;
	logic [7:0] portAPinIn, portBPinIn, port0PinOut, port1PinOut, port2PinOut, port3PinOut, port4PinOut;
	logic [7:0] port6PinOut, port8PinOut, port9PinOut, portAPinOut, portBPinOut, port0PinOe, port1PinOe;
	logic [7:0] port2PinOe, port3PinOe, port4PinOe, port6PinOe, port8PinOe, port9PinOe, portAPinOe, portBPinOe;
	logic [7:0] port0PullEn, port1PullEn, port6PullEn, port0PullupSel, port1PullupSel, port6PullupSel;
	logic [7:0] port4OpendrainSel, chipSelectOut, analogInEn, analogInSelect, extInterruptIn, extInterruptStopWake;
	logic [7:0] p3Misc;
	int fails = 0;
	int checksDone = 0;
	// hold request and ready come from the memory model
	assign port3PinIn = {p3Misc[7], readyLine, p3Misc[5], holdReq, p3Misc[3:0]};
	mcu_pin_function_mux DUT (.*);
	ext_bus_memory memory (.clock(clock), .p0Out(port0PinOut), .p0Oe(port0PinOe), .p1Out(port1PinOut),
		.p1Oe(port1PinOe), .p2Out(port2PinOut), .p3Out(port3PinOut), .holdWanted(holdWanted),
		.slowReady(slowReady), .p0In(port0PinIn), .p1In(port1PinIn), .holdReq(holdReq), .readyLine(readyLine));
	// ************************************************
	// clock, tasks and verdict
	// ************************************************
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic step(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic completeRun;
		if (fails == 0 && checksDone > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// watchdog far beyond the planned run
	initial
	begin
		repeat (2000) @(posedge clock);
		fails++;
		completeRun;
	end
	// ************************************************
	// scenarios
	// ************************************************
	initial
	begin
		{sys_rst, busAddrPhase, busDataDrive, addrLatchEn, readStrobe, writeStrobeLow, writeStrobeHigh, busClock,
			holdAckOut, chipSelectEn, clockMonitorOut, clockMonitorEn, twoWireEn, twoWireSdaOut, twoWireSclOut,
			holdWanted, slowReady, uartTxData, uartTxEn, uartClkOut, uartClkOutEn, pulseGenOut, pulseGenEn,
			compareEventOut, compareEventEn, busWriteData, busAddr, portData, portDirection, port2PinIn,
			port4PinIn, port6PinIn, port8PinIn, port9PinIn, portAPinIn, portBPinIn, port0PullupSel,
			port1PullupSel, port6PullupSel, port4OpendrainSel, chipSelectOut, analogInEn, p3Misc} = '0;
		modeSelectPin = 3'h3;
		sys_rst = 1'h1;
		step(10);
		sys_rst = 1'h0;
		step(5);
		// single chip: gpio, pull-ups, bus inputs ignored
		portData[7:0] = 8'hA5;
		portDirection[7:0] = 8'h0F;
		portDirection[47:40] = 8'hF0;
		port0PullupSel = 8'hFF;
		port6PullupSel = 8'h3C;
		port1PullupSel = 8'h3C;
		busAddr = 24'hABCDEF;
		busAddrPhase = 1'h1;
		holdWanted = 1'h1;
		step(3);
		chk("p0 drive", port0PinOut & port0PinOe, 8'h05);
		chk("p0 oe", port0PinOe, 8'h0F);
		chk("p0 pull", port0PullEn, 8'hF0);
		chk("p6 pull", port6PullEn, 8'h0C);
		chk("p1 pull", port1PullEn, 8'h3C);
		chk("p2 oe", port2PinOe, 8'h00);
		chk("mode", extBusMode, 1'h0);
		chk("hold gated", holdRequestIn, 1'h0);
		chk("ready", busReady, 1'h1);
		// port 4 serial and pulse, receive pins left as inputs
		holdWanted = 1'h0;
		{uartTxEn, uartTxData, uartClkOutEn, uartClkOut, pulseGenEn, pulseGenOut} = 12'h5AB;
		port4PinIn = 8'h0D;
		step(1);
		chk("p4 oe", port4PinOe, 8'hA2);
		chk("p4 out", port4PinOut & port4PinOe, 8'hA2);
		port4OpendrainSel = 8'h02;
		step(1);
		chk("p4 od high", port4PinOe, 8'hA0);
		uartTxData = 2'h0;
		step(1);
		chk("p4 od low", port4PinOut & port4PinOe, 8'hA0);
		chk("rx in", uartRxData, 2'h3);
		chk("clk in", uartClkIn, 2'h1);
		// compare, clock monitor, chip select, analog
		portDirection[47:40] = 8'h00;
		{compareEventEn, compareEventOut, clockMonitorEn, clockMonitorOut} = 10'h15F;
		{chipSelectEn, chipSelectOut, analogInEn} = 17'h1960F;
		port8PinIn = 8'hFF;
		portDirection[55:48] = 8'hFF;
		portData[55:48] = 8'hA5;
		step(2);
		chk("p6 oe", port6PinOe, 8'h58);
		chk("p6 out", port6PinOut & port6PinOe, 8'h58);
		chk("p8 oe", port8PinOe, 8'hF0);
		chk("p8 out", port8PinOut & port8PinOe, 8'hA0);
		chk("p6 pull alt", port6PullEn, 8'h24);
		chk("p9 out", port9PinOut, 8'h96);
		chk("analog sel", analogInSelect, 8'h0F);
		chk("p8 read", portRead[55:48], 8'hF0);
		chipSelectEn = 1'h0;
		step(1);
		chk("p9 off", port9PinOe, 8'h00);
		// port A and B inputs, two-wire SDA pin pulled low, SCL released
		{twoWireEn, twoWireSdaOut, twoWireSclOut} = 3'h5;
		portAPinIn = 8'h69;
		portBPinIn = 8'h41;
		portData[79:64] = 16'h3CC1;
		portDirection[79:72] = 8'h0F;
		step(2);
		chk("count a", countAInput, 2'h3);
		chk("count b", countBInput, 2'h0);
		chk("count z", countZInput, 2'h2);
		chk("two wire in", {twoWireSclIn, twoWireSdaIn}, 2'h1);
		chk("pa out", portAPinOut, 8'h01);
		chk("pb drive", portBPinOut & portBPinOe, 8'h0C);
		chk("irq in", extInterruptIn, 8'hC1);
		chk("trigger", converterTriggerIn, 1'h1);
		chk("stop wake", extInterruptStopWake, 8'hFF);
		chk("pa oe", portAPinOe, 8'h40);
		// mid-run reset into external bus mode
		modeSelectPin = 3'h0;
		sys_rst = 1'h1;
		step(2);
		sys_rst = 1'h0;
		addrLatchEn = 1'h1;
		step(5);
		chk("bus mode", extBusMode, 1'h1);
		chk("addr", {port2PinOut, port1PinOut, port0PinOut}, 24'hABCDEF);
		chk("addr oe", {port2PinOe, port1PinOe, port0PinOe}, 24'hFFFFFF);
		chk("latch", port3PinOut[0], 1'h1);
		{addrLatchEn, busAddrPhase, busDataDrive, writeStrobeLow, busClock} = 5'h07;
		busWriteData = 16'h1234;
		step(1);
		chk("write data", {port1PinOut, port0PinOut}, 16'h1234);
		chk("p1 pull bus", port1PullEn, 8'h00);
		chk("p3 oe", port3PinOe, 8'hAF);
		chk("p3 low", port3PinOut & 8'hAF, 8'h84);
		{writeStrobeLow, writeStrobeHigh} = 2'h1;
		step(1);
		chk("p3 high", port3PinOut & 8'hAF, 8'h88);
		{writeStrobeHigh, busDataDrive, readStrobe} = 3'h1;
		step(4);
		chk("read oe", port0PinOe, 8'h00);
		chk("read data", busReadData, 16'h97B5);
		slowReady = 1'h1;
		step(3);
		chk("ready low", busReady, 1'h0);
		{slowReady, holdWanted} = 2'h1;
		step(3);
		chk("hold req", holdRequestIn, 1'h1);
		holdAckOut = 1'h1;
		step(1);
		chk("hold oe", {port2PinOe, port0PinOe, port3PinOe}, 24'h0000A0);
		chk("hold ack", port3PinOut[5], 1'h1);
		step(1);
		chk("hold p1 oe", port1PinOe, 8'h00);
		completeRun;
	end
endmodule // mcu_pin_function_mux_bench
`default_nettype wire
